//--- rtl/ipc_ctrl.sv
// Idle and power-down mode controller for the core clock, strobes and ports
module ipc_ctrl #(
   parameter int PORT_W     = ipc_pkg::IPC_PORT_W,
   parameter int OSC_STABLE = ipc_pkg::IPC_OSC_STABLE_CYC
) (
   // Clock and reset
   input  wire logic               sys_clk,
   input  wire logic               reset,
   // Power control register access from the core
   input  wire logic               power_control_reg_wr,
   input  wire ipc_pkg::ipc_power_control_reg_t power_control_reg_wdata,
   output ipc_pkg::ipc_power_control_reg_t      power_control_reg_rdata,
   // Instruction and interrupt progress
   input  wire logic               instr_retire,
   input  wire logic               irq_active,
   input  wire logic               vector_taken,
   // External wake pins and their enables
   input  wire logic               ext_wake_irq_a_n,
   input  wire logic               ext_wake_irq_b_n,
   input  wire logic               wake_en_a,
   input  wire logic               wake_en_b,
   // Strobes and ports as the core drives them
   input  wire logic               cpu_ale,
   input  wire logic               cpu_fetch_strobe,
   input  wire logic [PORT_W-1:0]  cpu_port_out,
   // Strobes and ports at the pins
   output logic                    ale,
   output logic                    program_fetch_strobe,
   output logic [PORT_W-1:0]       port_out,
   // Clock control
   output logic                    cpu_clk_en,
   output logic                    periph_clk_en,
   output logic                    osc_enable,
   // Wake events and status
   output logic                    wake_irq_a,
   output logic                    wake_irq_b,
   output logic                    sfr_reinit,
   output ipc_pkg::ipc_stat_t      status
);
   import ipc_pkg::*;

   ipc_state_t            state;
   ipc_state_t            next_state;
   ipc_power_control_reg_t             power_control_reg;
   ipc_power_control_reg_t             next_power_control_reg;
   logic                  req_armed;
   logic [IPC_STAB_W-1:0] stab_cnt;
   logic [1:0]            wake_src;
   logic                  low_a;
   logic                  low_b;
   logic                  rel_a;
   logic                  rel_b;

   ipc_wake_pin u_pin_a (
      .sys_clk  (sys_clk),
      .reset    (reset),
      .pin_n    (ext_wake_irq_a_n),
      .enable   (wake_en_a),
      .held_low (low_a),
      .released (rel_a)
   );

   ipc_wake_pin u_pin_b (
      .sys_clk  (sys_clk),
      .reset    (reset),
      .pin_n    (ext_wake_irq_b_n),
      .enable   (wake_en_b),
      .held_low (low_b),
      .released (rel_b)
   );

   // Request decode
   wire wr_req     = power_control_reg_wr & (power_control_reg_wdata.idle_request_bit
                                | power_control_reg_wdata.powerdown_request_bit);
   wire armed_now  = req_armed | wr_req;
   wire pd_wanted  = power_control_reg_wr ? power_control_reg_wdata.powerdown_request_bit : power_control_reg.powerdown_request_bit;
   wire idl_wanted = power_control_reg_wr ? power_control_reg_wdata.idle_request_bit : power_control_reg.idle_request_bit;
   wire enter_go   = (state == IPC_RUN) & instr_retire & armed_now;
   wire enter_pd   = enter_go & pd_wanted;
   wire enter_idle = enter_go & ~pd_wanted & idl_wanted;
   wire any_low    = low_a | low_b;
   wire stab_done  = (stab_cnt == IPC_STAB_W'(OSC_STABLE - 1));
   // Exit once settled at the first release, or if the pin already went back high
   wire pd_exit    = (state == IPC_WAIT_REL) & (rel_a | rel_b | ~any_low);
   // Wakes from idle on any enabled interrupt; power-down ignores these
   wire idle_wake  = (state == IPC_IDLE) & irq_active;
   wire clr_idl    = vector_taken | idle_wake;
   wire clr_pd     = vector_taken;

   // Mode sequencing
   always_comb begin
      next_state = state;
      unique case (state)
         IPC_RUN: begin
            if (enter_pd) begin
               next_state = IPC_PDOWN;
            end else if (enter_idle) begin
               next_state = IPC_IDLE;
            end
         end
         IPC_IDLE: begin
            if (idle_wake) begin
               next_state = IPC_RUN;
            end
         end
         IPC_PDOWN: begin
            if (any_low) begin
               next_state = IPC_RESTART;
            end
         end
         IPC_RESTART: begin
            if (stab_done) begin
               next_state = IPC_WAIT_REL;
            end
         end
         IPC_WAIT_REL: begin
            if (pd_exit) begin
               next_state = IPC_RUN;
            end
         end
         default: begin
            next_state = IPC_RUN;
         end
      endcase
   end

   // Register update: a software write wins over a hardware clear in the same cycle
   always_comb begin
      next_power_control_reg = power_control_reg;
      if (power_control_reg_wr) begin
         next_power_control_reg = power_control_reg_wdata;
         next_power_control_reg.rsvd = 1'b0;
      end else begin
         if (clr_idl) begin
            next_power_control_reg.idle_request_bit = 1'b0;
         end
         if (clr_pd) begin
            next_power_control_reg.powerdown_request_bit = 1'b0;
         end
      end
   end

   // Reset puts every control bit back, power-down bit included
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state <= IPC_RUN;
         power_control_reg  <= IPC_POWER_CONTROL_REG_RST;
      end else begin
         state <= next_state;
         power_control_reg  <= next_power_control_reg;
      end
   end

   // One entry per write, so bits left set after a wake do not re-enter
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         req_armed <= 1'b0;
      end else begin
         req_armed <= armed_now & ~enter_go;
      end
   end

   // Settle counter runs only while the oscillator restarts
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         stab_cnt <= '0;
      end else if (state == IPC_RESTART) begin
         stab_cnt <= stab_cnt + IPC_STAB_W'(1);
      end else begin
         stab_cnt <= '0;
      end
   end

   // Collect which pins were low, the interrupt logic picks priority
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         wake_src   <= 2'h0;
         wake_irq_a <= 1'b0;
         wake_irq_b <= 1'b0;
      end else begin
         wake_irq_a <= pd_exit & (wake_src[0] | low_a);
         wake_irq_b <= pd_exit & (wake_src[1] | low_b);
         if (state == IPC_PDOWN) begin
            wake_src <= {low_b, low_a};
         end else if (state == IPC_RESTART || state == IPC_WAIT_REL) begin
            wake_src <= wake_src | {low_b, low_a};
         end else begin
            wake_src <= 2'h0;
         end
      end
   end

   // Clock gating from the coming state, so outputs match the state register
   wire nx_run  = (next_state == IPC_RUN);
   wire nx_idle = (next_state == IPC_IDLE);
   wire nx_pd   = (next_state == IPC_PDOWN);

   // CPU holds its registers simply because its clock stops; nothing is cleared
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         cpu_clk_en    <= 1'b1;
         periph_clk_en <= 1'b1;
         osc_enable    <= 1'b1;
      end else begin
         cpu_clk_en    <= nx_run;
         periph_clk_en <= ~nx_pd & (next_state != IPC_RESTART);
         osc_enable    <= ~nx_pd;
      end
   end

   // Ports freeze at the entry value; strobes high in idle, low in power-down
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         port_out             <= '1;
         ale                  <= 1'b1;
         program_fetch_strobe <= 1'b1;
      end else begin
         if (nx_run) begin
            port_out <= cpu_port_out;
         end
         ale                  <= nx_run ? cpu_ale : nx_idle;
         program_fetch_strobe <= nx_run ? cpu_fetch_strobe : nx_idle;
      end
   end

   // Reinit request lasts only while reset is in; a pin exit leaves registers alone
   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         sfr_reinit <= 1'b1;
      end else begin
         sfr_reinit <= 1'b0;
      end
   end

   assign power_control_reg_rdata = power_control_reg;
   assign status     = '{idle_active:      (state == IPC_IDLE),
                         powerdown_active: (state == IPC_PDOWN),
                         osc_restarting:   (state == IPC_RESTART)};

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (reset);

   property p_idle_entry;
      (state == IPC_RUN) && instr_retire && armed_now && !pd_wanted && idl_wanted
         |=> (state == IPC_IDLE) && !cpu_clk_en;
   endproperty
   a_idle_entry: assert property (p_idle_entry) else $error("idle not entered");

   property p_idle_clocks;
      (state == IPC_IDLE) |-> !cpu_clk_en && periph_clk_en && osc_enable;
   endproperty
   a_idle_clocks: assert property (p_idle_clocks) else $error("idle clocks wrong");

   property p_idle_strobes;
      (state == IPC_IDLE) |-> ale && program_fetch_strobe;
   endproperty
   a_idle_strobes: assert property (p_idle_strobes) else $error("strobes not high");

   property p_port_hold;
      (state == IPC_IDLE) && $past(state == IPC_IDLE) |-> $stable(port_out);
   endproperty
   a_port_hold: assert property (p_port_hold) else $error("port moved in idle");

   property p_idle_wake;
      (state == IPC_IDLE) && irq_active && !power_control_reg_wr
         |=> (state == IPC_RUN) && !power_control_reg.idle_request_bit && cpu_clk_en;
   endproperty
   a_idle_wake: assert property (p_idle_wake) else $error("idle wake failed");

   property p_pd_osc_off;
      (state == IPC_PDOWN) |-> !osc_enable && !cpu_clk_en && !periph_clk_en;
   endproperty
   a_pd_osc_off: assert property (p_pd_osc_off) else $error("oscillator runs");

   property p_pd_stay;
      (state == IPC_PDOWN) && !any_low |=> (state == IPC_PDOWN);
   endproperty
   a_pd_stay: assert property (p_pd_stay) else $error("power-down left early");

   property p_pd_restart;
      (state == IPC_PDOWN) && any_low |=> (state == IPC_RESTART) && osc_enable;
   endproperty
   a_pd_restart: assert property (p_pd_restart) else $error("no restart");

   // A pin already low may restart the oscillator one cycle on, so look at entry only
   property p_pd_dominant;
      (state == IPC_RUN) && instr_retire && wr_req && power_control_reg_wdata.powerdown_request_bit
         |=> (state == IPC_PDOWN) && !osc_enable && !periph_clk_en;
   endproperty
   a_pd_dominant: assert property (p_pd_dominant) else $error("power-down lost");

   property p_vector_clear;
      vector_taken && !power_control_reg_wr
         |=> !power_control_reg.idle_request_bit && !power_control_reg.powerdown_request_bit;
   endproperty
   a_vector_clear: assert property (p_vector_clear) else $error("bits not cleared");

   property p_exit_event;
      pd_exit |=> (state == IPC_RUN) && (wake_irq_a || wake_irq_b);
   endproperty
   a_exit_event: assert property (p_exit_event) else $error("exit without event");

   // Pin state is registered, so the enable one cycle back decides
   property p_wake_gated;
      (state == IPC_PDOWN) && !$past(wake_en_a) && !$past(wake_en_b)
         |=> (state == IPC_PDOWN);
   endproperty
   a_wake_gated: assert property (p_wake_gated) else $error("disabled pin woke");

   property p_hold_release;
      (state == IPC_WAIT_REL) && any_low && !rel_a && !rel_b |=> (state == IPC_WAIT_REL);
   endproperty
   a_hold_release: assert property (p_hold_release) else $error("exit before release");

   property p_reset_clears;
      $past(reset) |-> (power_control_reg == IPC_POWER_CONTROL_REG_RST) && sfr_reinit;
   endproperty
   a_reset_clears: assert property (p_reset_clears) else $error("reset value wrong");

   property p_pin_exit_kept;
      pd_exit && !power_control_reg_wr && !vector_taken |=> !sfr_reinit && $stable(power_control_reg);
   endproperty
   a_pin_exit_kept: assert property (p_pin_exit_kept) else $error("regs moved on exit");

   property p_pd_ports;
      (state == IPC_PDOWN) && $past(state == IPC_PDOWN) |-> $stable(port_out);
   endproperty
   a_pd_ports: assert property (p_pd_ports) else $error("port moved in pd");

   property p_idle_stay;
      (state == IPC_IDLE) && !irq_active |=> (state == IPC_IDLE);
   endproperty
   a_idle_stay: assert property (p_idle_stay) else $error("idle left early");

   c_idle_round: cover property ((state == IPC_IDLE) ##[1:20] (state == IPC_RUN));
   c_pd_wake: cover property ((state == IPC_WAIT_REL) ##1 wake_irq_a);
   c_both_low: cover property ((state == IPC_PDOWN) && low_a && low_b);
   c_write_clear: cover property (power_control_reg_wr && vector_taken);

endmodule

//--- rtl/ipc_pkg.sv
// Package for the idle and power-down controller: constants, types, states
// How it works
// - Setting the idle bit lets the current instruction retire, then idle begins.
// - Idle stops the CPU clock; interrupt, timer and serial clocks keep running.
// - Idle keeps all CPU registers, stack pointer, PC and status intact.
// - Port pins hold the levels they had when idle began.
// - Address latch and program fetch strobes sit high during idle.
// - An enabled interrupt in idle clears the idle bit and resumes execution.
// - After the handler returns, code continues after the instruction that slept.
// - Power-down stops the oscillator after the requesting instruction retires.
// - RAM and special registers keep contents throughout power-down.
// - Only reset or an external wake pin ends power-down.
// - Only the two external pins wake, each only when enabled.
// - Pin low restarts the oscillator; pin returning high completes the exit.
// - With both enabled, either low restarts; first release completes the exit.
// - Reset exit reinitialises special registers; pin exit leaves them untouched.
// - Neither exit alters internal RAM.
// - Both bits set: normal power-down exit; vectoring clears both, no idle.
// - Reset clears the power-down bit.
// - Any interrupt or reset clears the idle bit.
package ipc_pkg;

   // Power control register layout, bit 7 down to bit 0
   typedef struct packed {
      logic smod1;
      logic smod0;
      logic rsvd;
      logic pof;
      logic general_flag_one;
      logic general_flag_zero;
      logic powerdown_request_bit;
      logic idle_request_bit;
   } ipc_power_control_reg_t;

   // Status seen by the core and the clock tree
   typedef struct packed {
      logic idle_active;
      logic powerdown_active;
      logic osc_restarting;
   } ipc_stat_t;

   // Reset value 00X1_0000, reserved bit taken as zero
   localparam ipc_power_control_reg_t IPC_POWER_CONTROL_REG_RST = 8'h10;

   // Number of port pins frozen during idle
   localparam int IPC_PORT_W = 32;

   // Oscillator restart settle time in sys_clk cycles (no figure given)
   localparam int IPC_OSC_STABLE_CYC = 1024;
   localparam int IPC_STAB_W         = 16;

   // Reset hold needed to end idle, in oscillator periods
   localparam int IPC_RST_HOLD_OSC = 24;

   typedef enum logic [2:0] {
      IPC_RUN      = 3'b000,
      IPC_IDLE     = 3'b001,
      IPC_PDOWN    = 3'b010,
      IPC_RESTART  = 3'b011,
      IPC_WAIT_REL = 3'b100
   } ipc_state_t;

endpackage

//--- rtl/ipc_wake_pin.sv
// One external wake pin: enabled-low level and release pulse
module ipc_wake_pin (
   // Clock and reset
   input  wire logic sys_clk,
   input  wire logic reset,
   // Pin and its interrupt enable
   input  wire logic pin_n,
   input  wire logic enable,
   // Qualified pin state
   output logic      held_low,
   output logic      released
);
   import ipc_pkg::*;

   // Either sensing mode wakes, so the level alone qualifies
   wire low_now = enable & ~pin_n;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         held_low <= 1'b0;
         released <= 1'b0;
      end else begin
         held_low <= low_now;
         released <= held_low & ~low_now;
      end
   end

endmodule

//--- test/ipc_wake_model.sv
// Wake pin model standing for the external party on the two wake pins
module ipc_wake_model (
   // Clock
   input  wire logic sys_clk,
   // Oscillator restart status from the controller
   input  wire logic osc_restarting,
   // Wake pins, active low, idle high
   output logic      pin_a_n,
   output logic      pin_b_n
);
   timeunit 1ns;
   timeprecision 1ps;

   // Cycles seen restarting, and waits that ran out
   int settle_cnt = 0;
   int late       = 0;

   initial begin
      pin_a_n = 1'b1;
      pin_b_n = 1'b1;
   end

   // Held low until the oscillator has settled, then released in turn
   task automatic wake(input logic a, input logic b, input int hold);
      @(negedge sys_clk);
      pin_a_n = ~a;
      pin_b_n = ~b;
      settle_cnt = 0;
      repeat (3) @(negedge sys_clk);
      // Bounded: a restart still running after 50 cycles ends the wait and counts as late
      while (osc_restarting === 1'b1 && settle_cnt < 50) begin
         @(negedge sys_clk);
         settle_cnt++;
      end
      if (settle_cnt == 50) begin
         late++;
      end
      repeat (hold) @(negedge sys_clk);
      pin_a_n = 1'b1;
      repeat (hold) @(negedge sys_clk);
      pin_b_n = 1'b1;
   endtask
endmodule

//--- test/idle_powerdown_control_bench.sv
// Self-checking bench for the idle and power-down controller
module idle_powerdown_control_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import ipc_pkg::*;

   // Short settle time keeps the power-down runs brief
   localparam int STAB = 4;

   logic        sys_clk, reset, power_control_reg_wr, instr_retire, irq_active, vector_taken;
   logic        wake_en_a, wake_en_b, cpu_ale, cpu_fetch_strobe;
   logic        pin_a_n, pin_b_n, ale, program_fetch_strobe;
   logic        cpu_clk_en, periph_clk_en, osc_enable, wake_irq_a, wake_irq_b, sfr_reinit;
   logic [31:0] cpu_port_out, port_out, held, last_port;
   ipc_power_control_reg_t   power_control_reg_wdata, power_control_reg_rdata;
   ipc_stat_t   status;
   integer      seed, err_total, total_checks, cnt_a, cnt_b, ca, cb, n;
   logic [7:0]  d;

   ipc_ctrl #(.PORT_W(32), .OSC_STABLE(STAB)) dut_u (
      .sys_clk(sys_clk), .reset(reset), .power_control_reg_wr(power_control_reg_wr), .power_control_reg_wdata(power_control_reg_wdata),
      .power_control_reg_rdata(power_control_reg_rdata), .instr_retire(instr_retire), .irq_active(irq_active),
      .vector_taken(vector_taken), .ext_wake_irq_a_n(pin_a_n), .ext_wake_irq_b_n(pin_b_n),
      .wake_en_a(wake_en_a), .wake_en_b(wake_en_b), .cpu_ale(cpu_ale),
      .cpu_fetch_strobe(cpu_fetch_strobe), .cpu_port_out(cpu_port_out), .ale(ale),
      .program_fetch_strobe(program_fetch_strobe), .port_out(port_out),
      .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en), .osc_enable(osc_enable),
      .wake_irq_a(wake_irq_a), .wake_irq_b(wake_irq_b), .sfr_reinit(sfr_reinit),
      .status(status));

   ipc_wake_model model_u (
      .sys_clk(sys_clk), .osc_restarting(status.osc_restarting),
      .pin_a_n(pin_a_n), .pin_b_n(pin_b_n));

   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   // Core side strobes and port data keep moving so frozen outputs show
   always @(negedge sys_clk) begin
      cpu_port_out = $random(seed);
      cpu_ale = cpu_port_out[8];
      cpu_fetch_strobe = cpu_port_out[9];
   end

   // One-cycle wake pulses are counted where they stand
   always @(posedge sys_clk) begin
      if (wake_irq_a === 1'b1) cnt_a++;
      if (wake_irq_b === 1'b1) cnt_b++;
   end

   // Core port word as the design takes it, for the running-mode compare
   always @(posedge sys_clk) begin
      last_port <= cpu_port_out;
   end

   // Reserved bit always reads zero
   function automatic logic [7:0] exp_reg(input logic [7:0] v);
      return v & 8'hDF;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task automatic step(input int c);
      repeat (c) @(negedge sys_clk);
   endtask

   task automatic wr(input logic [7:0] v, input logic r);
      power_control_reg_wr = 1'b1;
      power_control_reg_wdata = ipc_power_control_reg_t'(v);
      instr_retire = r;
      step(1);
      power_control_reg_wr = 1'b0;
      instr_retire = 1'b0;
   endtask

   task automatic final_report();
      $display("checks %0d errors %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      seed = 16;
      err_total = 0;
      total_checks = 0;
      cnt_a = 0;
      cnt_b = 0;
      reset = 1'b1;
      power_control_reg_wr = 1'b0;
      power_control_reg_wdata = ipc_power_control_reg_t'(8'h00);
      instr_retire = 1'b0;
      irq_active = 1'b0;
      vector_taken = 1'b0;
      wake_en_a = 1'b0;
      wake_en_b = 1'b0;
      cpu_port_out = 32'h0000_0000;
      cpu_ale = 1'b0;
      cpu_fetch_strobe = 1'b0;
      step(16);
      chk(power_control_reg_rdata, 8'h10, "reset value");
      chk(sfr_reinit, 1'b1, "reinit in reset");
      reset = 1'b0;
      step(1);
      chk(sfr_reinit, 1'b0, "reinit after reset");
      // Random register words with no sleep request
      for (int i = 0; i < 8; i++) begin
         d = cpu_port_out[7:0] & 8'hFC;
         wr(d, 1'b1);
         chk(power_control_reg_rdata, exp_reg(d), "reg write");
         chk(cpu_clk_en, 1'b1, "no sleep without request");
         chk(port_out, last_port, "port follows core");
         chk({ale, program_fetch_strobe}, {last_port[8], last_port[9]}, "strobes follow");
      end
      // A write beats a vector clear in the same cycle; entry waits for a retire
      vector_taken = 1'b1;
      wr(8'h03, 1'b0);
      vector_taken = 1'b0;
      chk(power_control_reg_rdata, 8'h03, "write beats clear");
      // Idle request waits for the instruction to retire
      wr(8'h05, 1'b0);
      chk(cpu_clk_en, 1'b1, "clock before retire");
      instr_retire = 1'b1;
      step(1);
      instr_retire = 1'b0;
      chk({status.idle_active, cpu_clk_en, periph_clk_en, osc_enable}, 4'b1011, "idle");
      held = port_out;
      for (int i = 0; i < 6; i++) begin
         step(1);
         chk(port_out, held, "port frozen");
         chk({ale, program_fetch_strobe}, 2'b11, "strobes high");
         chk(power_control_reg_rdata, 8'h05, "state kept in idle");
      end
      irq_active = 1'b1;
      step(1);
      irq_active = 1'b0;
      chk({status.idle_active, cpu_clk_en}, 2'b01, "irq ends idle");
      chk(power_control_reg_rdata, 8'h04, "idle bit cleared, flag kept");
      // Idle ended by a reset held two machine cycles
      wr(8'h01, 1'b1);
      reset = 1'b1;
      step(24);
      chk({power_control_reg_rdata, cpu_clk_en}, 9'h021, "reset ends idle");
      reset = 1'b0;
      step(1);
      // Power-down exits: pin a, pin b, both, both bits set together
      for (int k = 0; k < 4; k++) begin
         d = (k == 3) ? 8'h03 : 8'h0E;
         wr(d, 1'b1);
         chk({osc_enable, cpu_clk_en, periph_clk_en}, 3'b000, "pd clocks");
         chk({status.powerdown_active, status.idle_active}, 2'b10, "pd state");
         irq_active = 1'b1;
         step(3);
         irq_active = 1'b0;
         chk(osc_enable, 1'b0, "irq ignored in pd");
         wake_en_a = (k != 1);
         wake_en_b = (k != 0);
         if (k == 0) begin
            model_u.wake(1'b0, 1'b1, 2);
            step(4);
            chk(osc_enable, 1'b0, "disabled pin ignored");
         end
         ca = cnt_a;
         cb = cnt_b;
         model_u.wake(k != 1, k != 0, 2);
         chk(model_u.settle_cnt, STAB - 1, "osc settle time");
         n = 0;
         while (cpu_clk_en !== 1'b1 && n < 50) begin
            step(1);
            n++;
         end
         if (n == 50) begin
            err_total++;
            $display("BAD t=%0t no wake", $time);
            break;
         end
         step(1);
         chk(cnt_a - ca, (k != 1), "pulse a");
         chk(cnt_b - cb, (k != 0), "pulse b");
         chk(power_control_reg_rdata, exp_reg(d), "regs kept on pin exit");
         vector_taken = 1'b1;
         step(1);
         vector_taken = 1'b0;
         chk(power_control_reg_rdata[1:0], 2'b00, "bits cleared on vector");
         step(1);
         chk({status.idle_active, cpu_clk_en}, 2'b01, "no idle after pd");
      end
      // Power-down ended by reset
      wr(8'h0E, 1'b1);
      reset = 1'b1;
      step(1);
      chk({sfr_reinit, osc_enable}, 2'b11, "reset exit");
      step(23);
      chk(power_control_reg_rdata, 8'h10, "regs reinit");
      reset = 1'b0;
      step(2);
      chk({cpu_clk_en, sfr_reinit}, 2'b10, "running after reset");
      chk(model_u.late, 0, "wake waits bounded");
      final_report();
   end
endmodule
